// *** rtl/cci_pkg.sv ***
// Purpose: shared constants, types and decode helpers for the call/clear execute block
// Assumes: 14-bit instruction words, 13-bit program counter, 8-bit data path
// Notes:   register offsets are byte addresses on a 32-bit apb bus
package cci_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int PC_W    = 13;
	localparam int INSTR_W = 14;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;
	localparam int LATCH_W = 5;
	localparam int ADDR_W  = 8;

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] OFS_PC_HIGH_LATCH = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS        = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PC            = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STACK_TOP     = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_ACCUMULATOR   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_WATCHDOG      = 8'h14;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int STAT_ZERO_BIT      = 2;
	localparam int STAT_POWERDOWN_BIT = 3;
	localparam int STAT_EXPIRY_BIT    = 4;
	localparam int LATCH_PAGE_HI      = 4;
	localparam int LATCH_PAGE_LO      = 3;
	localparam int WDT_PRESCALER_LSB  = 8;

	// ****************************************************************
	// values after reset
	// ****************************************************************
	localparam logic [PC_W-1:0]    RST_PC       = 13'h0000;
	localparam logic [LATCH_W-1:0] RST_LATCH    = 5'h00;
	localparam logic [DATA_W-1:0]  RST_ACC      = 8'h00;
	localparam logic               RST_ZERO     = 1'b0;
	localparam logic               RST_FLAG_N   = 1'b1;
	localparam logic [DATA_W-1:0]  RST_WDT      = 8'h00;

	// ****************************************************************
	// encodings and counts
	// ****************************************************************
	localparam logic [2:0]         OPC_CALL      = 3'b100;
	localparam logic [6:0]         OPC_REG_CLEAR = 7'b0000011;
	localparam logic [INSTR_W-1:0] OPC_ACC_CLEAR = 14'h0103;
	localparam logic [INSTR_W-1:0] OPC_WDT_CLEAR = 14'h0064;
	localparam logic [PC_W-1:0]    PC_STEP       = 13'h0001;
	localparam logic [DATA_W-1:0]  WDT_STEP      = 8'h01;
	localparam logic [DATA_W-1:0]  WDT_TOP       = 8'hFF;
	localparam int                 CALL_CYCLES   = 2;

	typedef enum logic {
		ST_EXEC,
		ST_CALL_FLUSH
	} cci_state_type;

	// ****************************************************************
	// instruction decode helpers
	// ****************************************************************
	function automatic logic cci_is_call(input logic [INSTR_W-1:0] w);
		return w[13:11] == OPC_CALL;
	endfunction

	function automatic logic cci_is_reg_clear(input logic [INSTR_W-1:0] w);
		return w[13:7] == OPC_REG_CLEAR;
	endfunction

endpackage

// *** rtl/cci_exec.sv ***
// Purpose: execute stage for subroutine call, data/accumulator clear and watchdog clear
// Assumes: one accepted instruction per enabled pclk cycle is one instruction cycle
// Notes:   registers on apb; wdt_tick arrives from the watchdog oscillator domain
//          only the latest return address is kept; a deeper stack sits outside
//
// What this block does
// - subroutine jump first pushes the next address, pc plus one, to stack top
// - jump opcode top bits 100, 11-bit target loads pc bits 10 to 0
// - pc bits 12 and 11 come from latch bits 4 and 3 on jump
// - subroutine jump takes exactly two instruction cycles, status flags untouched
// - watchdog clear, encoding 0x0064, zeroes watchdog counter in one cycle
// - watchdog clear zeroes prescaler, sets active-low expiry and powerdown flags
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

module cci_exec
	import cci_pkg::*;
(
	// clock, reset and freeze
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        ce,
	// apb register port
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [cci_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// instruction stream from fetch
	input  wire logic                        instr_valid,
	input  wire logic [cci_pkg::INSTR_W-1:0] instr_word,
	output logic                             instr_ready,
	// power and watchdog events
	input  wire logic                        sleep_enter,
	input  wire logic                        wdt_tick,
	// execute results, all from flops
	output logic      [cci_pkg::PC_W-1:0]    pc,
	output logic      [cci_pkg::PC_W-1:0]    stack_top,
	output logic                             stack_push,
	output logic                             reg_clear_en,
	output logic      [cci_pkg::FADDR_W-1:0] reg_clear_addr,
	output logic      [cci_pkg::DATA_W-1:0]  accumulator,
	output logic                             zero_flag,
	output logic                             expiry_flag_n,
	output logic                             powerdown_flag_n,
	output logic      [cci_pkg::DATA_W-1:0]  wdt_count
);
	import cci_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	cci_state_type              state_q,       state_d;
	logic [PC_W-1:0]            pc_q,          pc_d;
	logic [PC_W-1:0]            stack_top_q,   stack_top_d;
	logic                       stack_push_q;
	logic                       reg_clear_en_q;
	logic [FADDR_W-1:0]         reg_clear_addr_q;
	logic [DATA_W-1:0]          acc_q,         acc_d;
	logic                       zero_q,        zero_d;
	logic                       expiry_n_q,    expiry_n_d;
	logic                       powerdown_n_q, powerdown_n_d;
	logic [DATA_W-1:0]          wdt_cnt_q,     wdt_cnt_d;
	logic [DATA_W-1:0]          wdt_pre_q,     wdt_pre_d;
	logic [LATCH_W-1:0]         latch_q;
	logic [31:0]                prdata_q,      rd_mux;
	logic                       pslverr_q;
	logic                       tick_s1_q, tick_s2_q, tick_s3_q, tick_stable_q;

	// ****************************************************************
	// instruction decode
	// ****************************************************************
	// a refused word decodes to nothing, so it can wait on the bus safely
	wire logic take        = instr_valid & instr_ready;
	wire logic do_call     = take & cci_is_call(instr_word);
	wire logic do_reg_clr  = take & cci_is_reg_clear(instr_word);
	wire logic do_acc_clr  = take & (instr_word == OPC_ACC_CLEAR);
	wire logic do_wdt_clr  = take & (instr_word == OPC_WDT_CLEAR);
	// page bits of the latch above the 11-bit immediate
	wire logic [PC_W-1:0] call_target = {latch_q[LATCH_PAGE_HI:LATCH_PAGE_LO],
		instr_word[10:0]};

	// the flush cycle of a call refuses the next word, giving two cycles
	assign instr_ready = ce & (state_q == ST_EXEC);

	// ****************************************************************
	// apb decode
	// ****************************************************************
	// full-word compares; any other offset answers with an error
	wire logic setup_ph    = psel & ~penable;
	wire logic wr_access   = psel & penable & pwrite & ce;
	wire logic hit_latch   = paddr == OFS_PC_HIGH_LATCH;
	wire logic hit_status  = paddr == OFS_STATUS;
	wire logic hit_pc      = paddr == OFS_PC;
	wire logic hit_stack   = paddr == OFS_STACK_TOP;
	wire logic hit_acc     = paddr == OFS_ACCUMULATOR;
	wire logic hit_wdt     = paddr == OFS_WATCHDOG;
	wire logic hit_any     = hit_latch | hit_status | hit_pc | hit_stack | hit_acc | hit_wdt;
	wire logic wr_latch    = wr_access & hit_latch;
	wire logic wr_status   = wr_access & hit_status;

	// slave never stretches an access except while the block is frozen
	assign pready  = ce;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// read mux, sampled in the setup cycle so prdata comes from a flop
	always_comb begin
		rd_mux = 32'h0000_0000;
		// unmapped offsets keep this zero default
		if (hit_latch) begin
			rd_mux[LATCH_W-1:0] = latch_q;
		end else if (hit_status) begin
			rd_mux[STAT_ZERO_BIT]      = zero_q;
			rd_mux[STAT_POWERDOWN_BIT] = powerdown_n_q;
			rd_mux[STAT_EXPIRY_BIT]    = expiry_n_q;
		end else if (hit_pc) begin
			rd_mux[PC_W-1:0] = pc_q;
		end else if (hit_stack) begin
			rd_mux[PC_W-1:0] = stack_top_q;
		end else if (hit_acc) begin
			rd_mux[DATA_W-1:0] = acc_q;
		end else if (hit_wdt) begin
			rd_mux[DATA_W-1:0] = wdt_cnt_q;
			rd_mux[WDT_PRESCALER_LSB +: DATA_W] = wdt_pre_q;
		end
	end

	// read data and error answer are set up before the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (ce && setup_ph) begin
			prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_q <= ~hit_any;  // unmapped offsets answer with an error
		end
	end

	// page latch written by software only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q <= RST_LATCH;
		end else if (wr_latch) begin
			latch_q <= pwdata[LATCH_W-1:0];
		end
	end

	// ****************************************************************
	// watchdog tick synchroniser
	// ****************************************************************
	// third stage filters one-cycle glitches across the oscillator boundary
	// limitation: a tick shorter than two pclk cycles can be missed
	wire logic tick_agree = tick_s2_q == tick_s3_q;
	wire logic tick_rise  = tick_agree & tick_s3_q & ~tick_stable_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_s1_q     <= 1'b0;
			tick_s2_q     <= 1'b0;
			tick_s3_q     <= 1'b0;
			tick_stable_q <= 1'b0;
		end else if (ce) begin
			tick_s1_q     <= wdt_tick;
			tick_s2_q     <= tick_s1_q;
			tick_s3_q     <= tick_s2_q;
			tick_stable_q <= tick_agree ? tick_s3_q : tick_stable_q;
		end
	end

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	// sequencer and program counter
	always_comb begin
		state_d     = state_q;
		pc_d        = pc_q;
		stack_top_d = stack_top_q;
		case (state_q)
			ST_EXEC: begin
				if (do_call) begin
					stack_top_d = pc_q + PC_STEP;
					pc_d        = call_target;
					state_d     = ST_CALL_FLUSH;
				end else if (take) begin
					pc_d = pc_q + PC_STEP;
				end
			end
			ST_CALL_FLUSH: begin
				// nothing is taken; the offered word waits for the next cycle
				state_d = ST_EXEC;
			end
			default: begin
				state_d = ST_EXEC;
			end
		endcase
	end

	// accumulator and zero flag; a call never reaches this path
	always_comb begin
		acc_d  = acc_q;
		zero_d = zero_q;
		// software write first, so a clear below overrides it
		if (wr_status) begin
			zero_d = pwdata[STAT_ZERO_BIT];
		end
		// set wins over a software write in the same cycle
		if (do_reg_clr || do_acc_clr) begin
			zero_d = 1'b1;
		end
		if (do_acc_clr) begin
			acc_d = RST_ACC;
		end
	end

	// watchdog counter, prescaler and its status flags
	always_comb begin
		wdt_pre_d     = wdt_pre_q;
		wdt_cnt_d     = wdt_cnt_q;
		expiry_n_d    = expiry_n_q;
		powerdown_n_d = powerdown_n_q;
		// sleep only lowers the powerdown flag; only a clear raises it again
		if (sleep_enter) begin
			powerdown_n_d = 1'b0;
		end
		if (tick_rise) begin
			wdt_pre_d = wdt_pre_q + WDT_STEP;
			if (wdt_pre_q == WDT_TOP) begin
				wdt_cnt_d = wdt_cnt_q + WDT_STEP;
				if (wdt_cnt_q == WDT_TOP) begin
					expiry_n_d = 1'b0;
				end
			end
		end
		// clear has priority: counter is zeroed so no expiry can coincide
		if (do_wdt_clr) begin
			wdt_cnt_d     = RST_WDT;
			wdt_pre_d     = RST_WDT;
			expiry_n_d    = 1'b1;
			powerdown_n_d = 1'b1;
		end
	end

	// ****************************************************************
	// state registers
	// ****************************************************************
	// one enable gates every register, so a frozen core resumes where it stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q       <= ST_EXEC;
			pc_q          <= RST_PC;
			stack_top_q   <= RST_PC;
			acc_q         <= RST_ACC;
			zero_q        <= RST_ZERO;
			expiry_n_q    <= RST_FLAG_N;
			powerdown_n_q <= RST_FLAG_N;
			wdt_cnt_q     <= RST_WDT;
			wdt_pre_q     <= RST_WDT;
		end else if (ce) begin
			state_q       <= state_d;
			pc_q          <= pc_d;
			stack_top_q   <= stack_top_d;
			acc_q         <= acc_d;
			zero_q        <= zero_d;
			expiry_n_q    <= expiry_n_d;
			powerdown_n_q <= powerdown_n_d;
			wdt_cnt_q     <= wdt_cnt_d;
			wdt_pre_q     <= wdt_pre_d;
		end
	end

	// one-cycle strobes toward the stack and the data memory
	// the clear address holds after its strobe, so a slow memory may latch it late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_push_q     <= 1'b0;
			reg_clear_en_q   <= 1'b0;
			reg_clear_addr_q <= '0;
		end else if (ce) begin
			stack_push_q     <= do_call;
			reg_clear_en_q   <= do_reg_clr;
			reg_clear_addr_q <= do_reg_clr ? instr_word[FADDR_W-1:0] : reg_clear_addr_q;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// every result leaves straight from a flop, so no decode glitch reaches a pin
	assign pc               = pc_q;
	assign stack_top        = stack_top_q;
	assign stack_push       = stack_push_q;
	assign reg_clear_en     = reg_clear_en_q;
	assign reg_clear_addr   = reg_clear_addr_q;
	assign accumulator      = acc_q;
	assign zero_flag        = zero_q;
	assign expiry_flag_n    = expiry_n_q;
	assign powerdown_flag_n = powerdown_n_q;
	assign wdt_count        = wdt_cnt_q;

endmodule

// *** verification/cci_exec_props.sv ***
// Purpose: port assertions for call, clear and watchdog clear execution
// Assumes: ce is low only while no call or strobe is in flight
// Notes:   bound to every cci_exec instance
`timescale 1ns/1ps
module cci_exec_props
	import cci_pkg::*;
(
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        instr_valid,
	input wire logic [cci_pkg::INSTR_W-1:0] instr_word,
	input wire logic                        instr_ready,
	input wire logic [cci_pkg::PC_W-1:0]    pc,
	input wire logic [cci_pkg::PC_W-1:0]    stack_top,
	input wire logic                        stack_push,
	input wire logic                        reg_clear_en,
	input wire logic [cci_pkg::FADDR_W-1:0] reg_clear_addr,
	input wire logic [cci_pkg::DATA_W-1:0]  accumulator,
	input wire logic                        zero_flag,
	input wire logic                        powerdown_flag_n,
	input wire logic                        expiry_flag_n,
	input wire logic [cci_pkg::DATA_W-1:0]  wdt_count
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************************************
	// decode of taken instructions
	// ****************************************************************
	// instr_ready already folds in ce, so take means the edge really executes
	wire logic take = instr_valid & instr_ready;
	wire logic t_call = take & (instr_word[13:11] == OPC_CALL);
	wire logic t_reg = take & (instr_word[13:7] == OPC_REG_CLEAR);
	wire logic t_acc = take & (instr_word == OPC_ACC_CLEAR);
	wire logic t_wdt = take & (instr_word == OPC_WDT_CLEAR);
	// ****************************************************************
	// properties
	// ****************************************************************
	push_next_a: assert property (t_call |=> stack_push && stack_top == $past(pc) + PC_STEP)
		else $error("call pushed a wrong return address");
	push_pulse_a: assert property (stack_push |=> !stack_push)
		else $error("push strobe longer than one cycle");
	call_target_a: assert property (t_call |=> pc[10:0] == $past(instr_word[10:0]))
		else $error("call target not loaded");
	call_flush_a: assert property (t_call |=> !instr_ready ##1 !stack_push)
		else $error("call did not take two cycles");
	call_flags_a: assert property (t_call |=> $stable(zero_flag) && $stable(expiry_flag_n)
		&& $stable(powerdown_flag_n))
		else $error("call changed a status flag");
	wdt_zero_a: assert property (t_wdt |=> wdt_count == 8'h00)
		else $error("watchdog counter not cleared");
	wdt_flags_a: assert property (t_wdt |=> expiry_flag_n && powerdown_flag_n)
		else $error("watchdog clear left a flag low");
	reg_clear_a: assert property (t_reg |=> reg_clear_en && zero_flag
		&& reg_clear_addr == $past(instr_word[6:0]))
		else $error("register clear wrong");
	acc_clear_a: assert property (t_acc |=> accumulator == 8'h00 && zero_flag
		&& pc == $past(pc) + PC_STEP)
		else $error("accumulator clear wrong");
	cover property (t_call ##2 take);
	cover property (t_reg ##1 t_acc);
	cover property (t_wdt);
endmodule

bind cci_exec cci_exec_props u_props (.pclk(pclk), .presetn(presetn),
	.instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
	.pc(pc), .stack_top(stack_top), .stack_push(stack_push), .reg_clear_en(reg_clear_en),
	.reg_clear_addr(reg_clear_addr), .accumulator(accumulator), .zero_flag(zero_flag),
	.powerdown_flag_n(powerdown_flag_n), .expiry_flag_n(expiry_flag_n),
	.wdt_count(wdt_count));

// *** verification/cci_exec_tb.sv ***
// Purpose: self-checking bench for the call and clear execute block
// Assumes: ce high except for one freeze, so pready answers without wait states
// Notes:   a cycle model is compared with the ports at every falling edge
`timescale 1ns/1ps
module cci_exec_tb;
	import cci_pkg::*;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              ce = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic              instr_valid = 1'b0;
	logic [13:0]       instr_word = 14'h0;
	logic              sleep_enter = 1'b0;
	logic              wdt_tick = 1'b0;
	logic [31:0]       prdata, rd_q, r;
	logic              pready, pslverr, instr_ready, stack_push, reg_clear_en, err_q;
	logic [PC_W-1:0]   pc, stack_top;
	logic [6:0]        reg_clear_addr;
	logic [7:0]        accumulator, wdt_count;
	logic              zero_flag, expiry_flag_n, powerdown_flag_n;
	// model state of the core
	logic [12:0]       pc_m = 13'h0, st_m = 13'h0;
	logic [4:0]        lat_m = 5'h00;
	logic              z_m = 1'b0, pd_m = 1'b1, run_chk = 1'b0;
	logic              push_m = 1'b0, rce_m = 1'b0;
	logic [6:0]        rca_m = 7'h00;
	int                nt = 0, miscompares = 0, check_count = 0;
	logic [31:0]       seed = 32'h405F;

	cci_exec u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .sleep_enter(sleep_enter),
		.wdt_tick(wdt_tick), .pc(pc), .stack_top(stack_top), .stack_push(stack_push),
		.reg_clear_en(reg_clear_en), .reg_clear_addr(reg_clear_addr),
		.accumulator(accumulator), .zero_flag(zero_flag), .expiry_flag_n(expiry_flag_n),
		.powerdown_flag_n(powerdown_flag_n), .wdt_count(wdt_count));

	// ****************************************************************
	// helpers
	// ****************************************************************
	always #12.5 pclk = ~pclk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// apb master: entered at a rising edge, leaves one idle cycle behind
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// waits as long as the slave stretches; only the hang guard ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		if (wr && a == OFS_PC_HIGH_LATCH)
			lat_m = d[4:0];
		if (wr && a == OFS_STATUS)
			z_m = d[STAT_ZERO_BIT];
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// valid stays up on return so the next instruction follows back to back
	task exec(input logic [13:0] w);
		instr_valid <= 1'b1;
		instr_word <= w;
		do begin
			@(posedge pclk);
		end while (instr_ready !== 1'b1);
		push_m = (w[13:11] == OPC_CALL);
		rce_m = (w[13:7] == OPC_REG_CLEAR);
		if (rce_m)
			rca_m = w[6:0];
		if (w[13:11] == OPC_CALL) begin
			st_m = pc_m + PC_STEP;
			pc_m = {lat_m[4:3], w[10:0]};
		end else
			pc_m = pc_m + PC_STEP;
		if (w[13:7] == OPC_REG_CLEAR || w == OPC_ACC_CLEAR)
			z_m = 1'b1;
		if (w == OPC_WDT_CLEAR) begin
			pd_m = 1'b1;
			nt = 0;
		end
	endtask

	task idle();
		instr_valid <= 1'b0;
		@(posedge pclk);
	endtask

	// ****************************************************************
	// continuous comparison against the model
	// ****************************************************************
	always @(negedge pclk) begin
		if (run_chk) begin
			chk(32'(pc), 32'(pc_m));
			chk(32'(stack_top), 32'(st_m));
			chk(32'(accumulator), 32'h0);
			chk(32'(zero_flag), 32'(z_m));
			chk(32'(powerdown_flag_n), 32'(pd_m));
			chk(32'(expiry_flag_n), 32'h1);
			chk(32'(stack_push), 32'(push_m));
			chk(32'(reg_clear_en), 32'(rce_m));
			chk(32'(reg_clear_addr), 32'(rca_m));
			// strobes stand one cycle only
			push_m = 1'b0;
			rce_m = 1'b0;
		end
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		run_chk = 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(rd_q, (i == 1) ? 32'h18 : 32'h0);
		end
		apb(1'b1, 8'h18, 32'h0);
		chk(32'(err_q), 32'h1);
		apb(1'b1, OFS_PC, 32'h1234);
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			apb(1'b1, OFS_PC_HIGH_LATCH, r);
			apb(1'b1, OFS_STATUS, {29'h0, r[5], 2'h0});
			exec({OPC_CALL, (i == 0) ? 11'h7FF : (i == 1) ? 11'h000 : r[20:10]});
			exec({OPC_CALL, r[31:21]});
			exec({OPC_REG_CLEAR, r[6:0]});
			exec(OPC_ACC_CLEAR);
			exec({2'b11, r[11:0]});
			exec(OPC_WDT_CLEAR);
			idle();
			apb(1'b0, OFS_STACK_TOP, 32'h0);
			chk(rd_q, 32'(st_m));
		end
		// prescaler wraps into the counter after 256 ticks
		repeat (300) begin
			wdt_tick <= 1'b1;
			repeat (4) @(posedge pclk);
			wdt_tick <= 1'b0;
			repeat (4) @(posedge pclk);
			nt++;
		end
		repeat (8) @(posedge pclk);
		apb(1'b0, OFS_WATCHDOG, 32'h0);
		chk(rd_q, 32'((nt % 256) * 256 + nt / 256));
		sleep_enter <= 1'b1;
		@(posedge pclk);
		pd_m = 1'b0;
		sleep_enter <= 1'b0;
		exec(OPC_WDT_CLEAR);
		idle();
		apb(1'b0, OFS_WATCHDOG, 32'h0);
		chk(rd_q, 32'h0);
		// a low clock enable must hold the core even with a call on offer
		ce <= 1'b0;
		instr_valid <= 1'b1;
		instr_word <= {OPC_CALL, 11'h2A5};
		repeat (4) @(posedge pclk);
		ce <= 1'b1;
		exec({OPC_CALL, 11'h2A5});
		idle();
		end_of_test();
	end

	// hang guard, well beyond the few thousand cycles the run needs
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		end_of_test();
	end
endmodule
